// file: hw/sce_top.sv
// Condition evaluator of a two-element SIMD sequencer with an APB slave.
// Assumes requests, status and pin inputs are synchronous to pclk.
//
// What this block does
// - A true condition performs the operation, a false one aborts it.
// - An else part runs on the inverse of the if condition.
// - Element x and y status and sticky bits are kept apart per element.
// - An instruction without a condition field behaves as always true.
// - Zero test: zero flag or exclusive success; nonzero: not zero or failure.
// - Greater-than follows the signed/float formula; at-most is its complement.
// - Below-zero follows its formula; greater-or-equal is true when it is 0.
// - Status bits ac, av, mv, mn, sv, sz, sf, bit_test_result and each flag input have a true and a complement test.
// - Loop-not-expired exists together with its complement, loop-expired.
// - Loop done when the count equals one; endless loop never ends.
// - In SIMD mode each element evaluates conditions from its own status.
// - Stack status bits live in sticky_x only, never in sticky_y.
// - In SIMD mode compute, paired and unpaired-to-paired moves run per element on its own result.
// - In SIMD mode branch, call or loop decision needs both elements true.
// - Else of an indirect branch runs per element where it tests false.
// - Unpaired-to-paired move runs per element, same source for both.
// - Paired-to-unpaired move is the explicit one only, gated by x.
// - Post-modify memory move in SIMD runs when either element is true.
// - Pre-modify of a conditional memory move always happens.
// - In SISD mode only element x flags govern the whole operation.
// - With element select, flag2 test picks x, its complement picks y (y only in SIMD mode), for compute and moves; other ops see both true.
//
// The address map and the APB slave port are this design's own decisions.
`include "sce_consts.svh"
module sce_top
  import sce_pkg::*;
#(
  parameter int LC_W = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sce_flags_t status_x,
  input wire sce_flags_t status_y,
  input wire logic excl_x,
  input wire logic excl_ok_x,
  input wire logic excl_y,
  input wire logic excl_ok_y,
  input wire logic pc_stack_ovf,
  input wire logic loop_addr_stack_ovf,
  input wire logic loop_cnt_stack_ovf,
  input wire logic [LC_W-1:0] current_loop_count,
  input wire logic req_valid,
  input wire sce_op_t req_op,
  input wire logic req_has_cond,
  input wire sce_cond_t req_cond,
  input wire logic req_has_else,
  input wire logic [3:0] flag_pin_i,
  output logic [3:0] flag_pin_o,
  output logic [3:0] flag_pin_oe,
  output logic dec_valid,
  output logic exec_x,
  output logic exec_y,
  output logic else_x,
  output logic else_y,
  output logic branch_take,
  output logic mem_go,
  output logic premod_go
);
  sce_state_t st_reg;
  sce_state_t st_next;
  sce_elem_if #(.LC_W(LC_W)) elem_if[2] ();
  logic cx;
  logic cy;
  logic flag2_code;
  logic pe_op;
  logic wr;
  logic rd_setup;
  logic [3:0] elem_bits_x;
  logic [3:0] elem_bits_y;

  ////////////////////////////////////////////////////////////////////////////
  // One evaluator per element, each fed by its own status.
  assign elem_if[0].flags = status_x;
  assign elem_if[0].excl = excl_x;
  assign elem_if[0].excl_ok = excl_ok_x;
  assign elem_if[1].flags = status_y;
  assign elem_if[1].excl = excl_y;
  assign elem_if[1].excl_ok = excl_ok_y;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_elem
      assign elem_if[gi].pins = flag_pin_i;
      assign elem_if[gi].loop_cnt = current_loop_count;
      assign elem_if[gi].code = req_has_cond ? req_cond : C_ALWAYS;
      sce_cond_eval #(.LC_W(LC_W)) u_eval (
        .bus(elem_if[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Per-element outcome, with the flag2 element-select override.
  always_comb
  begin
    flag2_code = req_has_cond &&
                 (req_cond == C_FLAG2 || req_cond == C_NOT_FLAG2);
    pe_op = (req_op == OP_COMPUTE) || (req_op == OP_MOVE_PAIR) ||
            (req_op == OP_MOVE_U2P) || (req_op == OP_MOVE_P2U);
    cx = elem_if[0].cond_true;
    cy = elem_if[1].cond_true;
    if (st_reg.sel && flag2_code)
    begin
      if (pe_op)
      begin
        cx = (req_cond == C_FLAG2);
        cy = (req_cond == C_NOT_FLAG2);
      end
      else
      begin
        cx = 1'b1;
        cy = 1'b1;
      end
    end
  end

  // Sticky candidates taken from each element's own overflow bits.
  assign elem_bits_x = {status_x.sf, status_x.sv, status_x.mv, status_x.av};
  assign elem_bits_y = {status_y.sf, status_y.sv, status_y.mv, status_y.av};

  // APB phase decode; writes land in the access phase.
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: bus slave, flag pin latency, sticky bits and decisions.
  always_comb
  begin
    st_next = st_reg;

    // Decision outputs are pulses that follow each request by one cycle.
    st_next.dv = req_valid;
    st_next.do_x = 1'b0;
    st_next.do_y = 1'b0;
    st_next.else_x = 1'b0;
    st_next.else_y = 1'b0;
    st_next.take = 1'b0;
    st_next.mem_go = 1'b0;
    st_next.premod = 1'b0;
    if (req_valid)
    begin
      unique case (req_op)
        OP_COMPUTE, OP_MOVE_PAIR, OP_MOVE_U2P:
        begin
          st_next.do_x = cx;
          st_next.do_y = st_reg.simd && cy;
          st_next.else_x = req_has_else && !cx;
          st_next.else_y = req_has_else && st_reg.simd && !cy;
        end
        OP_MOVE_P2U:
        begin
          st_next.do_x = cx;
          st_next.else_x = req_has_else && !cx;
        end
        OP_MEM_POST, OP_MEM_PRE:
        begin
          st_next.do_x = cx;
          st_next.do_y = st_reg.simd && cy;
          st_next.mem_go = cx || (st_reg.simd && cy);
          st_next.premod = (req_op == OP_MEM_PRE);
        end
        OP_BRANCH, OP_LOOP:
        begin
          st_next.take = cx && (!st_reg.simd || cy);
          st_next.else_x = req_has_else && !cx;
          st_next.else_y = req_has_else && st_reg.simd && !cy;
        end
      endcase
    end

    // Sticky bits: events set, write-one clears, a set in the same cycle wins.
    if (wr && paddr == `SCE_OFF_STKX)
    begin
      st_next.stk_x = st_reg.stk_x & ~pwdata[6:0];
    end
    if (wr && paddr == `SCE_OFF_STKY)
    begin
      st_next.stk_y = st_reg.stk_y & ~pwdata[3:0];
    end
    st_next.stk_x[`SCE_STK_SF:`SCE_STK_AV] =
      st_next.stk_x[`SCE_STK_SF:`SCE_STK_AV] | elem_bits_x;
    st_next.stk_y = st_next.stk_y | elem_bits_y;
    st_next.stk_x[`SCE_STK_PC] = st_next.stk_x[`SCE_STK_PC] |
                                 pc_stack_ovf;
    st_next.stk_x[`SCE_STK_LA] = st_next.stk_x[`SCE_STK_LA] |
                                 loop_addr_stack_ovf;
    st_next.stk_x[`SCE_STK_LC] = st_next.stk_x[`SCE_STK_LC] |
                                 loop_cnt_stack_ovf;

    // Mode control register.
    if (wr && paddr == `SCE_OFF_CTRL)
    begin
      st_next.simd = pwdata[`SCE_CTRL_SIMD];
      st_next.sel = pwdata[`SCE_CTRL_SEL];
    end

    // Flag pin writes take effect after a fixed latency; a new write restarts
    // the wait, so software must space toggles of one pin by that much.
    if (st_reg.pend_v)
    begin
      if (st_reg.wait_cnt == 3'h1)
      begin
        st_next.dir = st_reg.pend[`SCE_FLAGS_DIR_LSB +: 4];
        st_next.val = st_reg.pend[`SCE_FLAGS_VAL_LSB +: 4];
        st_next.pend_v = 1'b0;
      end
      st_next.wait_cnt = st_reg.wait_cnt - 3'h1;
    end
    if (wr && paddr == `SCE_OFF_FLAGS)
    begin
      st_next.pend = pwdata[7:0];
      st_next.pend_v = 1'b1;
      st_next.wait_cnt = `SCE_FLAG_WAIT;
    end

    // Read data and error are captured in the setup phase.
    if (rd_setup)
    begin
      st_next.err = 1'b0;
      st_next.rdata = 32'h00000000;
      unique case (paddr)
        `SCE_OFF_CTRL:
          st_next.rdata = {30'h00000000, st_reg.sel, st_reg.simd};
        `SCE_OFF_FLAGS:
          st_next.rdata = {20'h00000, flag_pin_i, st_reg.val, st_reg.dir};
        `SCE_OFF_STKX: st_next.rdata = {25'h0000000, st_reg.stk_x};
        `SCE_OFF_STKY: st_next.rdata = {28'h0000000, st_reg.stk_y};
        `SCE_OFF_STATX: st_next.rdata = {20'h00000, status_x};
        `SCE_OFF_STATY: st_next.rdata = {20'h00000, status_y};
        `SCE_OFF_DEC:
          st_next.rdata = {24'h000000, st_reg.premod, st_reg.mem_go,
                           st_reg.take, st_reg.else_y, st_reg.else_x,
                           st_reg.do_y, st_reg.do_x, st_reg.dv};
        default: st_next.err = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.simd <= 1'(`SCE_CTRL_RST >> `SCE_CTRL_SIMD);
      st_reg.pend <= `SCE_FLAGS_RST;
      st_reg.stk_x <= `SCE_STKX_RST;
      st_reg.stk_y <= `SCE_STKY_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the slave never inserts wait states.
  assign pready = 1'b1;
  assign prdata = st_reg.rdata;
  assign pslverr = st_reg.err;
  assign flag_pin_oe = st_reg.dir;
  assign flag_pin_o = st_reg.val & st_reg.dir;
  assign dec_valid = st_reg.dv;
  assign exec_x = st_reg.do_x;
  assign exec_y = st_reg.do_y;
  assign else_x = st_reg.else_x;
  assign else_y = st_reg.else_y;
  assign branch_take = st_reg.take;
  assign mem_go = st_reg.mem_go;
  assign premod_go = st_reg.premod;
endmodule // sce_top

// file: hw/sce_consts.svh
// Offsets, field positions, reset values and counts of the condition evaluator.
// Assumes it is included by bare name from the top module, the evaluator and the bench.
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH
`define SCE_OFF_CTRL 8'h00
`define SCE_OFF_FLAGS 8'h04
`define SCE_OFF_STKX 8'h08
`define SCE_OFF_STKY 8'h0C
`define SCE_OFF_STATX 8'h10
`define SCE_OFF_STATY 8'h14
`define SCE_OFF_DEC 8'h18
`define SCE_CTRL_SIMD 0
`define SCE_CTRL_SEL 1
`define SCE_CTRL_RST 2'h0
`define SCE_FLAGS_RST 8'h00
`define SCE_FLAGS_DIR_LSB 0
`define SCE_FLAGS_VAL_LSB 4
`define SCE_FLAGS_PIN_LSB 8
`define SCE_FLAG_WAIT 3'h4
`define SCE_LOOP_DONE 32'h00000001
`define SCE_STK_AV 0
`define SCE_STK_MV 1
`define SCE_STK_SV 2
`define SCE_STK_SF 3
`define SCE_STK_PC 4
`define SCE_STK_LA 5
`define SCE_STK_LC 6
`define SCE_STKX_RST 7'h00
`define SCE_STKY_RST 4'h0
`endif

// file: hw/sce_pkg.sv
// Types shared by the condition evaluator, its element interface and top.
// Assumes the constants header is on the include path.
package sce_pkg;
  // Condition codes carried by a conditional instruction.
  typedef enum logic [5:0] {
    C_EQ, C_NE, C_GT, C_LT, C_GE, C_LE,
    C_AC, C_NOT_AC, C_AV, C_NOT_AV, C_MV, C_NOT_MV, C_MS, C_NOT_MS,
    C_SV, C_NOT_SV, C_SZ, C_NOT_SZ, C_SF, C_NOT_SF, C_TF, C_NOT_TF,
    C_FLAG0, C_NOT_FLAG0, C_FLAG1, C_NOT_FLAG1,
    C_FLAG2, C_NOT_FLAG2, C_FLAG3, C_NOT_FLAG3,
    C_NOT_LCE, C_LCE, C_FOREVER, C_ALWAYS
  } sce_cond_t;

  // Kinds of conditional operation.
  typedef enum logic [2:0] {
    OP_COMPUTE, OP_MOVE_PAIR, OP_MOVE_U2P, OP_MOVE_P2U,
    OP_MEM_POST, OP_MEM_PRE, OP_BRANCH, OP_LOOP
  } sce_op_t;

  // Arithmetic status of one processing element.
  typedef struct packed {
    logic az;
    logic an;
    logic av;
    logic ac;
    logic af;
    logic asat;
    logic mv;
    logic mn;
    logic sv;
    logic sz;
    logic sf;
    logic bit_test_result;
  } sce_flags_t;

  // Whole state of the top module.
  typedef struct packed {
    logic simd;
    logic sel;
    logic [3:0] dir;
    logic [3:0] val;
    logic [7:0] pend;
    logic pend_v;
    logic [2:0] wait_cnt;
    logic [6:0] stk_x;
    logic [3:0] stk_y;
    logic [31:0] rdata;
    logic err;
    logic dv;
    logic do_x;
    logic do_y;
    logic else_x;
    logic else_y;
    logic take;
    logic mem_go;
    logic premod;
  } sce_state_t;
endpackage : sce_pkg

// file: hw/sce_elem_if.sv
// Signals between the top and the per-element condition evaluator.
// Assumes the package is compiled first.
interface sce_elem_if #(parameter int LC_W = 32);
  import sce_pkg::*;
  sce_flags_t flags;
  logic excl;
  logic excl_ok;
  logic [3:0] pins;
  logic [LC_W-1:0] loop_cnt;
  sce_cond_t code;
  logic cond_true;
  modport eval (input flags, excl, excl_ok, pins, loop_cnt, code,
                output cond_true);
  modport drive (output flags, excl, excl_ok, pins, loop_cnt, code,
                 input cond_true);
endinterface : sce_elem_if

// file: hw/sce_cond_eval.sv
// Condition test of one processing element, purely combinational.
// Assumes the flags on the interface belong to this element alone.
`include "sce_consts.svh"
module sce_cond_eval
  import sce_pkg::*;
#(
  parameter int LC_W = 32
)
(
  sce_elem_if.eval bus
);
  logic signed_lt;
  logic below;
  logic above;

  ////////////////////////////////////////////////////////////////////////////
  // Ordered comparisons built from the ALU status bits.
  always_comb
  begin
    signed_lt = ~bus.flags.af & (bus.flags.an ^ (bus.flags.av &
                ~bus.flags.asat));
    below = signed_lt | (bus.flags.af & bus.flags.an & ~bus.flags.az);
    above = signed_lt | (bus.flags.af & bus.flags.an) | ~bus.flags.az;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One test per code; every code but the flag pin and loop count tests sees this element's own status only.
  always_comb
  begin
    unique case (bus.code)
      C_EQ: bus.cond_true = bus.flags.az | (bus.excl & bus.excl_ok);
      C_NE: bus.cond_true = ~bus.flags.az | (bus.excl & ~bus.excl_ok);
      C_GT: bus.cond_true = above;
      C_LE: bus.cond_true = ~above;
      C_LT: bus.cond_true = below;
      C_GE: bus.cond_true = ~below;
      C_AC: bus.cond_true = bus.flags.ac;
      C_NOT_AC: bus.cond_true = ~bus.flags.ac;
      C_AV: bus.cond_true = bus.flags.av;
      C_NOT_AV: bus.cond_true = ~bus.flags.av;
      C_MV: bus.cond_true = bus.flags.mv;
      C_NOT_MV: bus.cond_true = ~bus.flags.mv;
      C_MS: bus.cond_true = bus.flags.mn;
      C_NOT_MS: bus.cond_true = ~bus.flags.mn;
      C_SV: bus.cond_true = bus.flags.sv;
      C_NOT_SV: bus.cond_true = ~bus.flags.sv;
      C_SZ: bus.cond_true = bus.flags.sz;
      C_NOT_SZ: bus.cond_true = ~bus.flags.sz;
      C_SF: bus.cond_true = bus.flags.sf;
      C_NOT_SF: bus.cond_true = ~bus.flags.sf;
      C_TF: bus.cond_true = bus.flags.bit_test_result;
      C_NOT_TF: bus.cond_true = ~bus.flags.bit_test_result;
      C_FLAG0: bus.cond_true = bus.pins[0];
      C_NOT_FLAG0: bus.cond_true = ~bus.pins[0];
      C_FLAG1: bus.cond_true = bus.pins[1];
      C_NOT_FLAG1: bus.cond_true = ~bus.pins[1];
      C_FLAG2: bus.cond_true = bus.pins[2];
      C_NOT_FLAG2: bus.cond_true = ~bus.pins[2];
      C_FLAG3: bus.cond_true = bus.pins[3];
      C_NOT_FLAG3: bus.cond_true = ~bus.pins[3];
      C_NOT_LCE: bus.cond_true =
        bus.loop_cnt != LC_W'(`SCE_LOOP_DONE);
      C_LCE: bus.cond_true = bus.loop_cnt == LC_W'(`SCE_LOOP_DONE);
      C_FOREVER: bus.cond_true = 1'b0;
      C_ALWAYS: bus.cond_true = 1'b1;
      default: bus.cond_true = 1'b0;
    endcase
  end
endmodule // sce_cond_eval

// file: tb/sce_checker.sv
// Concurrent checks on the ports of the condition evaluator top.
// Assumes sce_pkg is compiled first and pclk is the only clock.
module sce_checker
  import sce_pkg::*;
#(
  parameter int LC_W = 32
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire sce_flags_t status_x,
  input wire logic excl_x,
  input wire logic excl_ok_x,
  input wire logic [LC_W-1:0] current_loop_count,
  input wire logic req_valid,
  input wire sce_op_t req_op,
  input wire logic req_has_cond,
  input wire sce_cond_t req_cond,
  input wire logic req_has_else,
  input wire logic [3:0] flag_pin_o,
  input wire logic [3:0] flag_pin_oe,
  input wire logic dec_valid,
  input wire logic exec_x,
  input wire logic exec_y,
  input wire logic else_x,
  input wire logic branch_take,
  input wire logic premod_go
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // A request, and a conditional compute or loop carrying a given code.
  sequence s_req;
    req_valid;
  endsequence
  sequence s_cmp(c);
    req_valid && req_op == OP_COMPUTE && req_has_cond && req_cond == c;
  endsequence
  sequence s_loop(c);
    req_valid && req_op == OP_LOOP && req_has_cond && req_cond == c;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_DEC_LAT: assert property (
    s_req |=> dec_valid)
    else $error("decision did not follow a request");
  AST_DEC_PULSE: assert property (
    s_req ##1 !req_valid |=> !dec_valid && !exec_x && !branch_take)
    else $error("decision outputs outlived one cycle");
  AST_NO_COND: assert property (
    req_valid && req_op == OP_COMPUTE && !req_has_cond |=> exec_x)
    else $error("unconditional compute was not performed");
  AST_EQ_X: assert property (
    s_cmp(C_EQ) |=> exec_x == $past(status_x.az | (excl_x & excl_ok_x)))
    else $error("zero test gave the wrong outcome");
  AST_ELSE_INV: assert property (
    req_valid && req_op == OP_COMPUTE && req_has_else |=> exec_x != else_x)
    else $error("else part did not take the inverse condition");
  AST_P2U_X_ONLY: assert property (
    req_valid && req_op == OP_MOVE_P2U |=> !exec_y)
    else $error("paired to unpaired move ran an implicit move");
  AST_PREMOD: assert property (
    req_valid && req_op == OP_MEM_PRE |=> premod_go)
    else $error("pre-modify was skipped");
  AST_LCE: assert property (
    s_loop(C_LCE) && current_loop_count != LC_W'(1) |=> !branch_take)
    else $error("loop ended with the count not at one");
  AST_FOREVER: assert property (
    s_loop(C_FOREVER) |=> dec_valid && !branch_take)
    else $error("endless loop terminated");
  AST_PIN_DIR: assert property (
    (flag_pin_o & ~flag_pin_oe) == 4'h0)
    else $error("flag pin value driven while not an output");
endmodule // sce_checker

bind sce_top sce_checker #(.LC_W(LC_W)) u_sce_checker (
  .pclk(pclk), .presetn(presetn), .status_x(status_x), .excl_x(excl_x),
  .excl_ok_x(excl_ok_x), .current_loop_count(current_loop_count),
  .req_valid(req_valid), .req_op(req_op), .req_has_cond(req_has_cond),
  .req_cond(req_cond), .req_has_else(req_has_else),
  .flag_pin_o(flag_pin_o), .flag_pin_oe(flag_pin_oe),
  .dec_valid(dec_valid), .exec_x(exec_x), .exec_y(exec_y),
  .else_x(else_x), .branch_take(branch_take), .premod_go(premod_go));

// file: tb/sce_partner.sv
// Model of the two processing elements' status and the program sequencer.
// Assumes the bench calls its tasks from one process, in step with pclk.
module sce_partner
  import sce_pkg::*;
#(
  parameter int LC_W = 32
)
(
  input wire logic pclk,
  output sce_flags_t status_x,
  output sce_flags_t status_y,
  output logic [1:0] excl,
  output logic [2:0] stk_ovf,
  output logic [LC_W-1:0] loop_cnt,
  output logic [3:0] pins,
  output logic req_valid,
  output sce_op_t req_op,
  output logic req_has_cond,
  output sce_cond_t req_cond,
  output logic req_has_else
);
  // Quiet values from time zero.
  initial
  begin
    status_x = '0;
    status_y = '0;
    excl = 2'h0;
    stk_ovf = 3'h0;
    loop_cnt = '0;
    pins = 4'h0;
    req_valid = 1'h0;
    req_op = OP_COMPUTE;
    req_has_cond = 1'h0;
    req_cond = C_ALWAYS;
    req_has_else = 1'h0;
  end
  // Each element owns its status word; the exclusive result is shared.
  task automatic set_st(input sce_flags_t fx, input sce_flags_t fy,
                        input logic [1:0] ex, input logic [3:0] p,
                        input logic [LC_W-1:0] lc);
    @(posedge pclk);
    status_x <= fx;
    status_y <= fy;
    excl <= ex;
    pins <= p;
    loop_cnt <= lc;
  endtask
  // One request, valid for a single cycle.
  task automatic issue(input sce_op_t op, input logic hc, input sce_cond_t c,
                       input logic he);
    @(posedge pclk);
    req_valid <= 1'h1;
    req_op <= op;
    req_has_cond <= hc;
    req_cond <= c;
    req_has_else <= he;
    @(posedge pclk);
    req_valid <= 1'h0;
  endtask
  // The single set of sequencer stacks reports overflow events here.
  task automatic stk_evt(input logic [2:0] e);
    @(posedge pclk);
    stk_ovf <= e;
    @(posedge pclk);
    stk_ovf <= 3'h0;
  endtask
endmodule // sce_partner

// file: tb/sce_tb_top.sv
// Self-checking bench of the condition evaluator top.
// Assumes the partner model supplies status, pins, stacks and requests.
`include "sce_consts.svh"
module sce_tb_top
  import sce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, dec;
  logic [31:0] pwdata, prdata, rd;
  sce_flags_t status_x, status_y;
  logic [1:0] excl;
  logic [2:0] stk;
  logic [31:0] lcnt;
  logic req_valid, req_has_cond, req_has_else;
  sce_op_t req_op;
  sce_cond_t req_cond;
  logic [3:0] pin_i, pin_o, pin_oe;
  int bad_count, num_checks, cyc;
  logic [11:0] fl_tab [3] = '{12'h000, 12'hFFF, 12'h35A};
  logic [1:0] ex_tab [3] = '{2'h3, 2'h2, 2'h0};
  logic [3:0] pin_tab [3] = '{4'h5, 4'hA, 4'hC};
  logic [31:0] lc_tab [3] = '{32'h1, 32'h7, 32'h0};
  ////////////////////////////////////////////////////////////////////////
  sce_top #(.LC_W(32)) u_sce_top (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status_x(status_x),
    .status_y(status_y), .excl_x(excl[1]), .excl_ok_x(excl[0]),
    .excl_y(excl[1]), .excl_ok_y(excl[0]), .pc_stack_ovf(stk[0]),
    .loop_addr_stack_ovf(stk[1]), .loop_cnt_stack_ovf(stk[2]),
    .current_loop_count(lcnt), .req_valid(req_valid), .req_op(req_op),
    .req_has_cond(req_has_cond), .req_cond(req_cond),
    .req_has_else(req_has_else), .flag_pin_i(pin_i), .flag_pin_o(pin_o),
    .flag_pin_oe(pin_oe), .dec_valid(dec[0]), .exec_x(dec[1]),
    .exec_y(dec[2]), .else_x(dec[3]), .else_y(dec[4]),
    .branch_take(dec[5]), .mem_go(dec[6]), .premod_go(dec[7]));
  sce_partner #(.LC_W(32)) u_sce_partner (
    .pclk(pclk), .status_x(status_x), .status_y(status_y), .excl(excl),
    .stk_ovf(stk), .loop_cnt(lcnt), .pins(pin_i), .req_valid(req_valid),
    .req_op(req_op), .req_has_cond(req_has_cond), .req_cond(req_cond),
    .req_has_else(req_has_else));
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Issues a request and compares the masked decision one cycle later.
  task automatic dchk(input sce_op_t op, input logic hc, input sce_cond_t c,
                      input logic he, input logic [7:0] m,
                      input logic [7:0] e);
    u_sce_partner.issue(op, hc, c, he);
    #1;
    chk("decision", {24'h0, e}, {24'h0, dec & m});
  endtask
  // Expected outcome of one condition code in one element.
  function automatic logic cx_of(sce_flags_t f, logic [1:0] ex,
                                 logic [3:0] p, logic [31:0] lc,
                                 sce_cond_t c);
    logic [11:0] v;
    logic lt;
    logic gt;
    int k;
    v = {f.ac, f.av, f.mv, f.mn, f.sv, f.sz, f.sf, f.bit_test_result, p[0], p[1], p[2],
         p[3]};
    lt = (!f.af && (f.an ^ (f.av && !f.asat))) || (f.af && f.an && !f.az);
    gt = (!f.af && (f.an ^ (f.av && !f.asat))) || (f.af && f.an) || !f.az;
    k = (int'(c) - 6) / 2;
    case (c)
      C_EQ: return f.az | (ex[1] & ex[0]);
      C_NE: return !f.az | (ex[1] & !ex[0]);
      C_GT: return gt;
      C_LT: return lt;
      C_GE: return !lt;
      C_LE: return !gt;
      C_NOT_LCE: return lc != 32'h1;
      C_LCE: return lc == 32'h1;
      C_FOREVER: return 1'h0;
      C_ALWAYS: return 1'h1;
      default: return v[11 - k] ^ c[0];
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // Free-running clock.
  initial
  begin
    pclk = 1'h0;
    forever
      #10 pclk = ~pclk;
  end
  // Cuts a hung run short.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Main sequence.
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `SCE_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'h0, 8'h1C, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    u_sce_partner.set_st(12'h800, 12'h000, 2'h0, 4'h5, 32'h1);
    apb(1'h0, `SCE_OFF_STATX, 32'h0);
    chk("status_x", 32'h800, rd);
    apb(1'h1, `SCE_OFF_CTRL, 32'h1);
    dchk(OP_COMPUTE, 1'h1, C_EQ, 1'h1, 8'hFF, 8'h13);
    dchk(OP_MOVE_PAIR, 1'h1, C_EQ, 1'h1, 8'hFF, 8'h13);
    dchk(OP_BRANCH, 1'h1, C_EQ, 1'h1, 8'h39, 8'h11);
    dchk(OP_MOVE_U2P, 1'h1, C_NE, 1'h0, 8'hFF, 8'h05);
    dchk(OP_MOVE_P2U, 1'h1, C_NE, 1'h0, 8'hFF, 8'h01);
    dchk(OP_BRANCH, 1'h1, C_EQ, 1'h0, 8'h21, 8'h01);
    dchk(OP_BRANCH, 1'h0, C_EQ, 1'h0, 8'h21, 8'h21);
    dchk(OP_LOOP, 1'h1, C_LCE, 1'h0, 8'h21, 8'h21);
    dchk(OP_MEM_POST, 1'h1, C_NE, 1'h0, 8'hC1, 8'h41);
    dchk(OP_MEM_PRE, 1'h1, C_AC, 1'h0, 8'hC1, 8'h81);
    apb(1'h1, `SCE_OFF_CTRL, 32'h3);
    dchk(OP_COMPUTE, 1'h1, C_FLAG2, 1'h0, 8'hFF, 8'h03);
    dchk(OP_COMPUTE, 1'h1, C_NOT_FLAG2, 1'h0, 8'hFF, 8'h05);
    apb(1'h1, `SCE_OFF_CTRL, 32'h0);
    dchk(OP_COMPUTE, 1'h1, C_NE, 1'h0, 8'hFF, 8'h01);
    dchk(OP_BRANCH, 1'h1, C_EQ, 1'h0, 8'h21, 8'h21);
    u_sce_partner.set_st(12'hA00, 12'h000, 2'h0, 4'h5, 32'h1);
    u_sce_partner.stk_evt(3'h7);
    apb(1'h0, `SCE_OFF_STKX, 32'h0);
    chk("sticky_x", 32'h71, rd);
    apb(1'h0, `SCE_OFF_STKY, 32'h0);
    chk("sticky_y", 32'h0, rd);
    u_sce_partner.set_st(12'h800, 12'h000, 2'h0, 4'h5, 32'h1);
    apb(1'h1, `SCE_OFF_STKX, 32'h7F);
    apb(1'h0, `SCE_OFF_STKX, 32'h0);
    chk("sticky_x", 32'h0, rd);
    apb(1'h1, `SCE_OFF_FLAGS, 32'h4);
    repeat (6) @(posedge pclk);
    #1;
    chk("pins", 32'h40, {24'h0, pin_oe, pin_o});
    apb(1'h1, `SCE_OFF_FLAGS, 32'h44);
    @(posedge pclk);
    #1;
    chk("pins", 32'h40, {24'h0, pin_oe, pin_o});
    repeat (4) @(posedge pclk);
    #1;
    chk("pins", 32'h44, {24'h0, pin_oe, pin_o});
    apb(1'h0, `SCE_OFF_FLAGS, 32'h0);
    chk("flags", 32'h544, rd);
    for (int i = 0; i < 3; i++)
    begin
      u_sce_partner.set_st(fl_tab[i], ~fl_tab[i], ex_tab[i], pin_tab[i],
                           lc_tab[i]);
      for (int c = 0; c < 34; c++)
        dchk(OP_COMPUTE, 1'h1, sce_cond_t'(c), 1'h0, 8'hFF,
             {6'h0, cx_of(fl_tab[i], ex_tab[i], pin_tab[i], lc_tab[i],
             sce_cond_t'(c)), 1'h1});
    end
    conclude();
  end
endmodule // sce_tb_top
